// ### logic/uart_irq_defines.vh
// Function
// (RQ1) Receive enable raises data interrupt per mode.
// (RQ2) FIFO receive source follows trigger level.
// (RQ3) Data-ready sets on load, clears when empty.
// (RQ4) Mask bits 0-3 clear gives polled mode.
// (RQ5) Line status reports overrun, errors, empties.
// (RQ6) Transmit enable raises empty or below-trigger interrupt.
// (RQ7) Line errors on received character raise interrupt.
// (RQ8) Modem delta bits raise modem interrupt.
// (RQ9) Mask bits 5-7 need unlock; bit 4 reserved.
// (RQ10) Flow pin rising edges raise change interrupt.
// (RQ11) Timeout after four characters plus twelve bits.
// (RQ12) Transmit source uses transmitter empty in RS-485.
// (RQ13) Line and modem reads clear their interrupts.
// (RQ14) Trigger clears below level; timeout on read.
// (RQ15) Transmit interrupt clears on status read, write.
// (RQ16) Flow characters interrupt; clear as specified.
// (RQ17) Codes for levels one to four.
// (RQ18) Codes for levels five to seven, none.
// (RQ19) Status read shows highest pending source only.
// (RQ20) Status bit 0 low while interrupt pending.
// (RQ21) Status bits 7:6 show FIFO enable.
// (RQ22) FIFO control bit 0 gates whole write.
// (RQ23) Line control bit 7 selects divisor latches.
// (RQ24) Request output follows any enabled pending source.
// (RQ25) Mask resets to zero.
`ifndef UART_IRQ_DEFINES_VH
`define UART_IRQ_DEFINES_VH

`define IDX_DATA        4'h0
`define IDX_MASK        4'h1
`define IDX_STATUS      4'h2
`define IDX_LINE_CTRL   4'h3
`define IDX_MODEM_CTRL  4'h4
`define IDX_LINE_STAT   4'h5
`define IDX_MODEM_STAT  4'h6
`define IDX_SCRATCH     4'h7
`define IDX_ENH         4'h9

`define RST_MASK        8'h00
`define RST_LINE_CTRL   8'h00
`define RST_MODEM_CTRL  8'h00
`define RST_ENH         8'h00
`define RST_FIFO_CTRL   8'h00
`define RST_DIVISOR     8'h00

`define MASK_RX         0
`define MASK_TX         1
`define MASK_LINE       2
`define MASK_MODEM      3
`define MASK_RSVD       4
`define MASK_XCHAR      5
`define MASK_OUT_PIN    6
`define MASK_IN_PIN     7
`define LCR_DIV         7
`define MCR_FLOW_SEL    2
`define EFR_UNLOCK      4
`define EFR_AUTO_OUT    6
`define EFR_AUTO_IN     7
`define FCR_ENABLE      0
`define FCR_RX_RESET    1
`define FCR_TX_RESET    2

`define SRC_LINE        6'h06
`define SRC_RXDATA      6'h04
`define SRC_TIMEOUT     6'h0C
`define SRC_TRANSMIT_READY_SOURCE       6'h02
`define SRC_MODEM       6'h00
`define SRC_XCHAR       6'h10
`define SRC_FLOWPIN     6'h20
`define SRC_NONE        6'h01

`define TIMEOUT_CHARS   7'h04
`define TIMEOUT_BITS    7'h0C

`endif

// ### logic/pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 4
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_sync_out
);
	reg [WIDTH-1:0] stage_one;

	// Two flip-flops per pin; only the second stage leaves this module.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_one    <= {WIDTH{1'b0}};
			pin_sync_out <= {WIDTH{1'b0}};
		end else begin
			stage_one    <= pin_in;
			pin_sync_out <= stage_one;
		end
	end
endmodule // pin_sync

// ### logic/irq_priority.v
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module irq_priority (
	input  wire [6:0] pending,
	output reg  [5:0] source_code
);
	// Level one is pending[0] and wins over every other level.
	always @* begin
		if (pending[0]) begin
			source_code = `SRC_LINE; // RQ17
		end else if (pending[1]) begin
			source_code = `SRC_RXDATA; // RQ17
		end else if (pending[2]) begin
			source_code = `SRC_TIMEOUT; // RQ17
		end else if (pending[3]) begin
			source_code = `SRC_TRANSMIT_READY_SOURCE; // RQ17
		end else if (pending[4]) begin
			source_code = `SRC_MODEM; // RQ18
		end else if (pending[5]) begin
			source_code = `SRC_XCHAR; // RQ18
		end else if (pending[6]) begin
			source_code = `SRC_FLOWPIN; // RQ18
		end else begin
			source_code = `SRC_NONE; // RQ18
		end
	end
endmodule // irq_priority

// ### logic/uart_channel_interrupt_logic.v
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module uart_channel_interrupt_logic (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [7:0]  rx_data,
	input  wire        rx_char_loaded,
	input  wire        rx_fifo_empty,
	input  wire        rx_at_trigger,
	input  wire [3:0]  rx_line_errors,
	input  wire        rx_fifo_error,
	input  wire        thr_empty,
	input  wire        tx_below_trigger,
	input  wire        tx_fifo_empty,
	input  wire        transmitter_empty,
	input  wire        rs485_auto,
	input  wire [7:0]  modem_status_in,
	input  wire        xon_detected,
	input  wire        xoff_detected,
	input  wire        special_detected,
	input  wire        bit_tick,
	input  wire [3:0]  char_bits,
	input  wire        cts_n_pin,
	input  wire        dsr_n_pin,
	input  wire        rts_n_pin,
	input  wire        dtr_n_pin,
	output reg         irq,
	output reg         fifo_enable,
	output reg  [7:0]  fifo_control,
	output reg  [7:0]  line_control,
	output reg  [7:0]  modem_control,
	output reg  [7:0]  enhanced_feature_control,
	output reg  [7:0]  interrupt_mask,
	output reg  [15:0] divisor,
	output reg         rx_read,
	output reg         tx_write,
	output reg  [7:0]  tx_data,
	output reg         modem_status_read
);
	wire [3:0] pins_synced;
	wire [5:0] current_code;
	wire [6:0] pending_enabled;
	wire [7:0] mask_effective;
	wire [7:0] line_status;
	wire [7:0] interrupt_source_status;
	wire [3:0] acc_index;
	wire       acc_valid;
	wire       rd_now;
	wire       tx_condition;
	wire       in_pin_sel;
	wire       out_pin_sel;
	wire [6:0] timeout_limit;
	wire       data_read;
	wire       data_write;
	wire       status_read;

	reg        dp_write;
	reg  [3:0] dp_index;
	reg  [7:0] scratch;
	reg        line_pend;
	reg        timeout_pend;
	reg        tx_pend;
	reg        tx_condition_prev;
	reg        modem_pend;
	reg        modem_delta_prev;
	reg        xchar_pend;
	reg        special_pend;
	reg        flow_pend;
	reg        in_pin_prev;
	reg        out_pin_prev;
	reg  [6:0] timeout_count;
	reg  [7:0] next_rdata;

	function is_read;
		input [3:0] idx;
		begin
			is_read = rd_now && (acc_index == idx);
		end
	endfunction

	pin_sync #(
		.WIDTH (4)
	) u_pin_sync (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.pin_in       ({dtr_n_pin, rts_n_pin, dsr_n_pin, cts_n_pin}),
		.pin_sync_out (pins_synced)
	);

	assign acc_valid = hsel && htrans[1] && hready;
	assign acc_index = haddr[5:2];
	assign rd_now    = acc_valid && !hwrite;

	// Holding register accesses count only while the divisor latches are hidden.
	assign data_read   = rd_now && (acc_index == `IDX_DATA) && !line_control[`LCR_DIV]; // RQ14 RQ23
	assign data_write  = dp_write && (dp_index == `IDX_DATA) && !line_control[`LCR_DIV]; // RQ15 RQ23
	assign status_read = rd_now && (acc_index == `IDX_STATUS); // RQ15 RQ16

	// Bits 5 to 7 count only while the unlock bit stands; bit 4 never counts.
	assign mask_effective = interrupt_mask & {{3{enhanced_feature_control[`EFR_UNLOCK]}}, 1'b0, 4'hF}; // RQ9

	// Bit 0 shows data present; bits 1-4 are the head byte's errors.
	assign line_status = {rx_fifo_error, transmitter_empty, thr_empty, rx_line_errors, !rx_fifo_empty}; // RQ3 RQ5

	// Transmit source follows trigger or empty FIFO, the empty holding register with FIFOs off, or the whole transmitter in RS-485.
	assign tx_condition = rs485_auto ? transmitter_empty :
		(fifo_enable ? (tx_below_trigger || tx_fifo_empty) : thr_empty); // RQ6 RQ12

	// Modem control bit 2 picks the DTR/DSR pair over RTS/CTS.
	assign in_pin_sel  = modem_control[`MCR_FLOW_SEL] ? pins_synced[1] : pins_synced[0]; // RQ10
	assign out_pin_sel = modem_control[`MCR_FLOW_SEL] ? pins_synced[3] : pins_synced[2]; // RQ10

	// Receive data is a level: trigger in FIFO mode, one held character otherwise.
	assign pending_enabled[0] = line_pend && mask_effective[`MASK_LINE]; // RQ7
	assign pending_enabled[1] = mask_effective[`MASK_RX] &&
		(fifo_enable ? rx_at_trigger : !rx_fifo_empty); // RQ1 RQ2 RQ14
	assign pending_enabled[2] = timeout_pend && mask_effective[`MASK_RX]; // RQ11
	assign pending_enabled[3] = tx_pend && mask_effective[`MASK_TX]; // RQ6
	assign pending_enabled[4] = modem_pend && mask_effective[`MASK_MODEM]; // RQ8
	assign pending_enabled[5] = (xchar_pend || special_pend) && mask_effective[`MASK_XCHAR]; // RQ16
	assign pending_enabled[6] = flow_pend && (mask_effective[`MASK_OUT_PIN] || mask_effective[`MASK_IN_PIN]); // RQ10

	irq_priority u_irq_priority (
		.pending     (pending_enabled),
		.source_code (current_code)
	);

	assign interrupt_source_status = {fifo_enable, fifo_enable, current_code}; // RQ19 RQ20 RQ21

	assign timeout_limit = {3'h0, char_bits} * `TIMEOUT_CHARS + `TIMEOUT_BITS; // RQ11

	// Read data mux; divisor latches replace data and mask when line control bit 7 is set.
	always @* begin
		next_rdata = 8'h00;
		if (acc_index == `IDX_DATA) begin
			next_rdata = line_control[`LCR_DIV] ? divisor[7:0] : rx_data; // RQ23
		end else if (acc_index == `IDX_MASK) begin
			next_rdata = line_control[`LCR_DIV] ? divisor[15:8] : interrupt_mask; // RQ23
		end else if (acc_index == `IDX_STATUS) begin
			next_rdata = interrupt_source_status; // RQ19
		end else if (acc_index == `IDX_LINE_CTRL) begin
			next_rdata = line_control;
		end else if (acc_index == `IDX_MODEM_CTRL) begin
			next_rdata = modem_control;
		end else if (acc_index == `IDX_LINE_STAT) begin
			next_rdata = line_status; // RQ4 RQ5
		end else if (acc_index == `IDX_MODEM_STAT) begin
			next_rdata = modem_status_in;
		end else if (acc_index == `IDX_SCRATCH) begin
			next_rdata = scratch;
		end else if (acc_index == `IDX_ENH) begin
			next_rdata = enhanced_feature_control;
		end
	end

	// Bus slave: zero wait states, read data registered at the address phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			dp_write  <= 1'b0;
			dp_index  <= 4'h0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				dp_write <= acc_valid && hwrite;
				dp_index <= acc_index;
			end
			if (rd_now) begin
				hrdata <= {24'h000000, next_rdata};
			end
		end
	end

	// Register writes land in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interrupt_mask           <= `RST_MASK; // RQ25
			line_control             <= `RST_LINE_CTRL;
			modem_control            <= `RST_MODEM_CTRL;
			enhanced_feature_control <= `RST_ENH;
			fifo_control             <= `RST_FIFO_CTRL;
			fifo_enable              <= 1'b0;
			divisor                  <= {`RST_DIVISOR, `RST_DIVISOR};
			scratch                  <= 8'h00;
			tx_write                 <= 1'b0;
			tx_data                  <= 8'h00;
		end else begin
			tx_write                   <= 1'b0;
			fifo_control[`FCR_RX_RESET] <= 1'b0;
			fifo_control[`FCR_TX_RESET] <= 1'b0;
			if (dp_write) begin
				if (dp_index == `IDX_DATA) begin
					if (line_control[`LCR_DIV]) begin
						divisor[7:0] <= hwdata[7:0]; // RQ23
					end else begin
						tx_write <= 1'b1;
						tx_data  <= hwdata[7:0];
					end
				end else if (dp_index == `IDX_MASK) begin
					if (line_control[`LCR_DIV]) begin
						divisor[15:8] <= hwdata[7:0]; // RQ23
					end else begin
						interrupt_mask[3:0]         <= hwdata[3:0];
						interrupt_mask[`MASK_RSVD]  <= 1'b0; // RQ9
						if (enhanced_feature_control[`EFR_UNLOCK]) begin
							interrupt_mask[7:5] <= hwdata[7:5]; // RQ9
						end
					end
				end else if (dp_index == `IDX_STATUS) begin
					fifo_enable <= hwdata[`FCR_ENABLE]; // RQ22
					if (hwdata[`FCR_ENABLE]) begin
						fifo_control <= hwdata[7:0]; // RQ22
					end else begin
						fifo_control <= `RST_FIFO_CTRL; // RQ22
					end
				end else if (dp_index == `IDX_LINE_CTRL) begin
					line_control <= hwdata[7:0];
				end else if (dp_index == `IDX_MODEM_CTRL) begin
					modem_control <= hwdata[7:0];
				end else if (dp_index == `IDX_SCRATCH) begin
					scratch <= hwdata[7:0];
				end else if (dp_index == `IDX_ENH) begin
					enhanced_feature_control <= hwdata[7:0];
				end
			end
		end
	end

	// Read side effects, taken at the accepted address phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_read           <= 1'b0;
			modem_status_read <= 1'b0;
		end else begin
			rx_read           <= data_read;
			modem_status_read <= is_read(`IDX_MODEM_STAT);
		end
	end

	// Sticky sources: an event in the cycle of its clear wins.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_pend <= 1'b0;
		end else begin
			line_pend <= (rx_char_loaded && (|rx_line_errors)) ||
				(line_pend && !is_read(`IDX_LINE_STAT)); // RQ7 RQ13
		end
	end

	// Transmit source is edge triggered so a standing empty condition interrupts once.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pend           <= 1'b0;
			tx_condition_prev <= 1'b0;
		end else begin
			tx_condition_prev <= tx_condition;
			tx_pend <= (tx_condition && !tx_condition_prev) ||
				(tx_pend && !(status_read && current_code == `SRC_TRANSMIT_READY_SOURCE) && !data_write); // RQ6 RQ15
		end
	end

	// Modem source fires when the delta bits go from none set to at least one set.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			modem_pend       <= 1'b0;
			modem_delta_prev <= 1'b0;
		end else begin
			modem_delta_prev <= |modem_status_in[3:0];
			modem_pend <= ((|modem_status_in[3:0]) && !modem_delta_prev) ||
				(modem_pend && !is_read(`IDX_MODEM_STAT)); // RQ8 RQ13
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xchar_pend   <= 1'b0;
			special_pend <= 1'b0;
		end else begin
			xchar_pend <= xon_detected || xoff_detected ||
				(xchar_pend && !(status_read && current_code == `SRC_XCHAR)); // RQ16
			special_pend <= special_detected ||
				(special_pend && !rx_char_loaded && !(status_read && current_code == `SRC_XCHAR)); // RQ16
		end
	end

	// Flow pins are compared after synchronisation; only a low to high change counts.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flow_pend    <= 1'b0;
			in_pin_prev  <= 1'b0;
			out_pin_prev <= 1'b0;
		end else begin
			in_pin_prev  <= in_pin_sel;
			out_pin_prev <= out_pin_sel;
			flow_pend <= (enhanced_feature_control[`EFR_AUTO_IN] && in_pin_sel && !in_pin_prev) ||
				(enhanced_feature_control[`EFR_AUTO_OUT] && out_pin_sel && !out_pin_prev) ||
				(flow_pend && !is_read(`IDX_MODEM_STAT)); // RQ10 RQ13
		end
	end

	// Timeout timer counts bit times while data sits unread.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_count <= 7'h00;
		end else if (rx_char_loaded || rx_fifo_empty || data_read) begin
			timeout_count <= 7'h00;
		end else if (bit_tick && timeout_count < timeout_limit) begin
			timeout_count <= timeout_count + 7'h01;
		end
	end

	// The flag rises once, on the tick that brings the count to its limit.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_pend <= 1'b0;
		end else begin
			timeout_pend <= (!rx_fifo_empty && bit_tick && timeout_count + 7'h01 == timeout_limit) ||
				(timeout_pend && !data_read); // RQ11 RQ14
		end
	end

	// Request output goes high while any enabled source waits.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |pending_enabled; // RQ4 RQ24
		end
	end
endmodule // uart_channel_interrupt_logic

// ### verif/uart_irq_props.sv
`timescale 1ns/1ps
module uart_irq_props (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire [3:0]  rx_line_errors,
	input wire        rx_fifo_error,
	input wire        rx_fifo_empty,
	input wire        thr_empty,
	input wire        transmitter_empty,
	input wire        irq,
	input wire        fifo_enable,
	input wire [7:0]  line_control,
	input wire [7:0]  enhanced_feature_control,
	input wire [7:0]  interrupt_mask,
	input wire [15:0] divisor,
	input wire        modem_status_read
);
	reg       ap_w;
	reg       ap_r;
	reg [3:0] ap_idx;
	wire      quiet;
	wire [7:0] lsr_in;
	assign quiet = interrupt_mask[3:0] == 4'h0 && !(enhanced_feature_control[4] && interrupt_mask[7:5] != 3'h0);
	assign lsr_in = {rx_fifo_error, transmitter_empty, thr_empty, rx_line_errors, !rx_fifo_empty};
	// Remembers the address phase that the current data phase belongs to.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_w   <= 1'b0;
			ap_r   <= 1'b0;
			ap_idx <= 4'h0;
		end else if (hready) begin
			ap_w   <= hsel && htrans[1] && hwrite;
			ap_r   <= hsel && htrans[1] && !hwrite;
			ap_idx <= haddr[5:2];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_mask_reset_zero: assert property (!$past(hresetn) |-> interrupt_mask == 8'h00)
		else $error("mask not zero after reset");
	a_polled_no_irq: assert property (quiet && $past(quiet) && $past(quiet, 2) |-> !irq)
		else $error("irq raised with all sources masked");
	a_fifo_bit_gate: assert property (ap_w && ap_idx == 4'h2 |=> fifo_enable == $past(hwdata[0]))
		else $error("fifo enable does not follow written bit");
	a_divisor_steer: assert property (ap_w && ap_idx == 4'h0 && line_control[7] |=> divisor[7:0] == $past(hwdata[7:0]))
		else $error("divisor low not written");
	a_mask_write: assert property (ap_w && ap_idx == 4'h1 && !line_control[7] |=> interrupt_mask[3:0] == $past(hwdata[3:0]))
		else $error("mask low bits not written");
	a_status_fifo: assert property (ap_r && ap_idx == 4'h2 |-> hrdata[7:6] == {2{$past(fifo_enable)}})
		else $error("status fifo bits wrong");
	a_none_flag: assert property (ap_r && ap_idx == 4'h2 |-> hrdata[0] == (hrdata[5:0] == 6'h01))
		else $error("status pending flag wrong");
	a_line_view: assert property (ap_r && ap_idx == 4'h5 |-> hrdata[7:0] == $past(lsr_in))
		else $error("line status read wrong");
	a_modem_read_pulse: assert property (ap_r && ap_idx == 4'h6 |-> modem_status_read)
		else $error("modem read not signalled");
endmodule // uart_irq_props

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
	input  logic        hclk,
	input  logic        hready,
	input  logic [31:0] hrdata,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// One single word transfer; waits for hready at each phase.
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {26'h0, idx, 2'h0};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata[7:0];
	endtask
endmodule // host_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        rx_char_loaded, rx_fifo_empty, rx_at_trigger, rx_fifo_error, thr_empty, tx_below_trigger;
	logic        tx_fifo_empty, transmitter_empty, rs485_auto, xon_detected, xoff_detected, special_detected;
	logic        bit_tick, cts_n_pin, dsr_n_pin, rts_n_pin, dtr_n_pin, hsel, hwrite, hreadyout, hresp, irq;
	logic        fifo_enable, rx_read, tx_write, modem_status_read;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  rx_line_errors, char_bits;
	logic [7:0]  rx_data, modem_status_in, fifo_control, line_control, modem_control, enhanced_feature_control;
	logic [7:0]  interrupt_mask, tx_data, v;
	logic [15:0] divisor;
	logic [31:0] haddr, hwdata, hrdata, seed;
	int          err_count, checks_done;
	always #50 hclk = ~hclk;
	host_model host_model_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	uart_channel_interrupt_logic uart_channel_interrupt_logic_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
		.hreadyout, .hresp, .rx_data, .rx_char_loaded, .rx_fifo_empty, .rx_at_trigger, .rx_line_errors,
		.rx_fifo_error, .thr_empty, .tx_below_trigger, .tx_fifo_empty, .transmitter_empty, .rs485_auto,
		.modem_status_in, .xon_detected, .xoff_detected, .special_detected, .bit_tick, .char_bits, .cts_n_pin,
		.dsr_n_pin, .rts_n_pin, .dtr_n_pin, .irq, .fifo_enable, .fifo_control, .line_control, .modem_control,
		.enhanced_feature_control, .interrupt_mask, .divisor, .rx_read, .tx_write, .tx_data, .modem_status_read
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] lsr_now();
		return {rx_fifo_error, transmitter_empty, thr_empty, rx_line_errors, !rx_fifo_empty};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
		host_model_i.xfer(1'b0, idx, 8'h00, v);
		chk(v, exp);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		host_model_i.xfer(1'b1, idx, d, v);
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish;
	end
	initial begin
		{rx_char_loaded, rx_at_trigger, rx_fifo_error, thr_empty, tx_below_trigger, tx_fifo_empty} = 6'h00;
		{transmitter_empty, rs485_auto, xon_detected, xoff_detected, special_detected, bit_tick} = 6'h00;
		{cts_n_pin, dsr_n_pin, rts_n_pin, dtr_n_pin} = 4'h0;
		rx_fifo_empty = 1'b1;
		rx_line_errors = 4'h0;
		char_bits = 4'hA;
		rx_data = 8'h00;
		modem_status_in = 8'h00;
		seed = 32'hF29BEC67;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h01);
		wr(4'h2, 8'h01);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			{rx_fifo_error, transmitter_empty, thr_empty, rx_line_errors, rx_fifo_empty} <= seed[7:0];
			{dsr_n_pin, rts_n_pin, dtr_n_pin, tx_below_trigger} <= seed[19:16];
			rx_data <= seed[15:8];
			@(posedge hclk);
			rd(4'h5, lsr_now());
		end
		chk(fifo_control, 8'h01);
		// A received character with an error while every source is masked.
		rx_line_errors <= 4'h2;
		rx_fifo_empty <= 1'b0;
		rx_char_loaded <= 1'b1;
		tx_below_trigger <= 1'b0;
		@(posedge hclk);
		rx_char_loaded <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({7'h0, irq}, 8'h00);
		rd(4'h5, lsr_now());
		wr(4'h3, 8'h80);
		wr(4'h0, 8'h34);
		wr(4'h1, 8'h12);
		wr(4'h3, 8'h03);
		chk(divisor[7:0], 8'h34);
		chk(divisor[15:8], 8'h12);
		rd(4'h1, 8'h00);
		wr(4'h9, 8'h90);
		wr(4'h1, 8'hEF);
		rd(4'h1, 8'hEF);
		rx_at_trigger <= 1'b1;
		tx_fifo_empty <= 1'b1;
		modem_status_in <= 8'h01;
		xon_detected <= 1'b1;
		bit_tick <= 1'b1;
		rx_char_loaded <= 1'b1;
		@(posedge hclk);
		xon_detected <= 1'b0;
		rx_char_loaded <= 1'b0;
		repeat (60) @(posedge hclk);
		bit_tick <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({7'h0, irq}, 8'h01);
		rd(4'h2, 8'hC6);
		rd(4'h2, 8'hC6);
		rd(4'h5, lsr_now());
		rd(4'h2, 8'hC4);
		rx_at_trigger <= 1'b0;
		rx_fifo_empty <= 1'b1;
		rd(4'h2, 8'hCC);
		rd(4'h0, rx_data);
		rd(4'h2, 8'hC2);
		rd(4'h2, 8'hC0);
		host_model_i.xfer(1'b0, 4'h6, 8'h00, v);
		rd(4'h2, 8'hD0);
		rd(4'h2, 8'hC1);
		special_detected <= 1'b1;
		rx_line_errors <= 4'h0;
		@(posedge hclk);
		special_detected <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({7'h0, irq}, 8'h01);
		rx_char_loaded <= 1'b1;
		@(posedge hclk);
		rx_char_loaded <= 1'b0;
		rd(4'h2, 8'hC1);
		cts_n_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		rd(4'h2, 8'hE0);
		host_model_i.xfer(1'b0, 4'h6, 8'h00, v);
		rd(4'h2, 8'hC1);
		chk({7'h0, irq}, 8'h00);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h01);
		chk(fifo_control, 8'h00);
		wr(4'h9, 8'h00);
		xon_detected <= 1'b1;
		@(posedge hclk);
		xon_detected <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({7'h0, irq}, 8'h00);
		thr_empty <= 1'b0;
		@(posedge hclk);
		thr_empty <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({7'h0, irq}, 8'h01);
		wr(4'h0, 8'h5A);
		@(negedge hclk);
		chk({7'h0, tx_write}, 8'h01);
		chk(tx_data, 8'h5A);
		rd(4'h2, 8'h01);
		tally_and_finish;
	end
endmodule // tb
bind uart_channel_interrupt_logic uart_irq_props uart_irq_props_i (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .rx_line_errors,
	.rx_fifo_error, .rx_fifo_empty, .thr_empty, .transmitter_empty, .irq, .fifo_enable, .line_control,
	.enhanced_feature_control, .interrupt_mask, .divisor, .modem_status_read
);
